// ===== inc/dlp_pkg.sv
// Package for the dial link command parser: character codes, result codes, carriers.
// Assumes byte-wide characters on one system clock.
package dlp_pkg;
  // ==========================================================================
  // Character codes
  localparam logic [7:0] CH_A = 8'h41;
  localparam logic [7:0] CH_T = 8'h54;
  localparam logic [7:0] CH_D = 8'h44;
  localparam logic [7:0] CH_H = 8'h48;
  localparam logic [7:0] CH_V = 8'h56;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CASE_MASK = 8'hdf;
  // ==========================================================================
  // Result codes and sizes
  localparam logic [2:0] RES_OK = 3'h0;
  localparam logic [2:0] RES_CONNECT = 3'h1;
  localparam logic [2:0] RES_ERROR = 3'h4;
  localparam int ADDR_DIGITS = 5;
  localparam int PLUS_COUNT = 3;
  localparam int MAX_ARGS = 7;
  localparam logic [16:0] ADDR_RESET = 17'h00000;
  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } dlp_char_s;
  typedef struct packed {
    logic open;
    logic [16:0] addr;
  } dlp_link_s;
endpackage

// ===== logic/dlp_parser.sv
// Dial link command parser for the master's payload port.
// Assumes characters arrive as one-cycle strobes from a UART on clock_i;
// the reply path can take one character per cycle (no back-pressure).
//
// Contract
// [RULE1] Commands are parsed only while dial_mode_enable is on.
// [RULE2] In dial mode, scan port characters, recognise only supported AT subset.
// [RULE3] Dial command with a unit address opens a virtual link to it.
// [RULE4] Host supplies five decimal address digits, leading zero padded.
// [RULE5] Completed dial reports code 1, or CONNECT when verbose.
// [RULE6] While connected, pass characters through until three plus characters.
// [RULE7] Link persists until a new dial address or hang-up arrives.
// [RULE8] Hang-up or plus escape drops the link and reports OK.
// [RULE9] Bare attention answers OK; erroneous command answers ERROR.
// [RULE10] Verbosity 0 numeric, 1 text, text default; answers OK.
// [RULE11] Non-command characters echo; second attention prefix closes the link.
// [RULE12] Dial acknowledgment is made locally with no far-end check.
// [RULE13] Payload passes only between master port and addressed remote.
// [RULE14] While a link is open no other radio carries payload.
// [RULE15] Polling simulator issues no polls unless a link is open.
// [RULE16] Diagnostic traffic runs regardless of link state.
// [RULE17] Carriage return ends a line; prefix letters match regardless of case.
`timescale 1ns/1ps
module dlp_parser
  import dlp_pkg::*;
(
  input wire logic clock_i, // System clock, 25 MHz
  input wire logic resetn_i, // Synchronous reset, active low
  input wire logic dial_mode_enable_i, // Dial mode on at this master
  input wire dlp_char_s host_char_i, // Character from host port
  input wire logic poll_req_i, // Polling simulator wants to poll
  input wire logic diag_req_i, // Diagnostic traffic request
  output dlp_char_s reply_o, // Echo and result text to host
  output dlp_char_s payload_o, // Payload toward the radio link
  output dlp_link_s link_o, // Open link and target address
  output logic others_block_o, // Other radios barred from payload
  output logic poll_en_o, // Polling simulator allowed
  output logic diag_en_o // Diagnostic traffic allowed
);
  // ==========================================================================
  // Functions
  function automatic logic [7:0] upc(input logic [7:0] c);
    upc = (c >= 8'h61 && c <= 8'h7a) ? (c & CASE_MASK) : c;
  endfunction
  function automatic logic is_dig(input logic [7:0] c);
    is_dig = (c >= CH_0) && (c <= CH_9);
  endfunction

  typedef enum {ST_IDLE, ST_GOT_A, ST_LINE} dlp_cmd_e;

  // ==========================================================================
  // State
  dlp_cmd_e cmd_ff;
  logic [7:0] line_ff [MAX_ARGS];
  logic [2:0] len_ff;
  logic ovf_ff;
  logic [1:0] plus_ff;
  logic verbose_ff;
  logic open_ff;
  logic [16:0] addr_ff;
  logic [2:0] res_ff;
  logic res_go_ff;
  logic [3:0] txpos_ff;
  logic tx_busy_ff;
  dlp_char_s reply_ff;
  dlp_char_s payload_ff;

  logic [7:0] ch;
  logic chv;
  assign ch = upc(host_char_i.data);
  assign chv = host_char_i.valid & dial_mode_enable_i; // see [RULE1]

  // Decode a finished line held in line_ff (after AT)
  logic [16:0] dial_addr;
  logic dial_ok, hang_ok, vrb_ok, bare_ok;
  always_comb begin
    dial_addr = 17'h00000;
    dial_ok = (len_ff == 3'(ADDR_DIGITS + 2)) && !ovf_ff
      && line_ff[0] == CH_D && line_ff[1] == CH_T; // see [RULE4]
    for (int i = 0; i < ADDR_DIGITS; i++) begin
      dial_ok = dial_ok & is_dig(line_ff[i + 2]);
      dial_addr = 17'(dial_addr * 17'd10 + 17'(line_ff[i + 2] - CH_0));
    end
    hang_ok = (len_ff == 3'd1) && !ovf_ff && line_ff[0] == CH_H;
    vrb_ok = (len_ff == 3'd2) && !ovf_ff && line_ff[0] == CH_V
      && (line_ff[1] == CH_0 || line_ff[1] == CH_1);
    bare_ok = (len_ff == 3'd0) && !ovf_ff;
  end

  logic line_end;
  assign line_end = chv && cmd_ff == ST_LINE && ch == CH_CR; // see [RULE17]
  logic esc_hit;
  assign esc_hit = chv && open_ff && ch == CH_PLUS && plus_ff == 2'(PLUS_COUNT - 1);

  // ==========================================================================
  // Command scanner: AT prefix then argument bytes until carriage return
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      cmd_ff <= ST_IDLE;
      len_ff <= 3'd0;
      ovf_ff <= 1'b0;
    end else if (chv) begin // see [RULE2]
      case (cmd_ff)
        ST_IDLE: cmd_ff <= (ch == CH_A) ? ST_GOT_A : ST_IDLE; // see [RULE17]
        ST_GOT_A: begin
          cmd_ff <= (ch == CH_T) ? ST_LINE : (ch == CH_A) ? ST_GOT_A : ST_IDLE;
          len_ff <= 3'd0;
          ovf_ff <= 1'b0;
        end
        ST_LINE: begin
          if (ch == CH_CR) begin
            cmd_ff <= ST_IDLE;
          end else if (len_ff == 3'(MAX_ARGS)) begin
            ovf_ff <= 1'b1; // Long lines become errors, not truncation
          end else begin
            len_ff <= len_ff + 3'd1;
          end
        end
        default: cmd_ff <= ST_IDLE;
      endcase
    end
  end

  // Argument capture, one slot per position
  generate
    for (genvar g = 0; g < MAX_ARGS; g++) begin : g_arg
      always_ff @(posedge clock_i) begin
        if (!resetn_i) begin
          line_ff[g] <= 8'h00;
        end else if (chv && cmd_ff == ST_LINE && ch != CH_CR && len_ff == 3'(g)) begin
          line_ff[g] <= ch;
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Escape detector: counts consecutive plus characters while linked
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      plus_ff <= 2'd0;
    end else if (chv) begin
      if (!open_ff || ch != CH_PLUS || esc_hit) plus_ff <= 2'd0;
      else plus_ff <= plus_ff + 2'd1; // see [RULE6]
    end
  end

  // ==========================================================================
  // Link state and verbosity
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      open_ff <= 1'b0;
      addr_ff <= ADDR_RESET;
    end else if (!dial_mode_enable_i) begin
      open_ff <= 1'b0;
    end else if (esc_hit) begin
      open_ff <= 1'b0; // see [RULE8]
    end else if (line_end && dial_ok) begin
      open_ff <= 1'b1; // see [RULE3]
      addr_ff <= dial_addr; // see [RULE7]
    end else if (line_end && hang_ok) begin
      open_ff <= 1'b0; // see [RULE8]
    end else if (chv && cmd_ff == ST_GOT_A && ch == CH_T) begin
      open_ff <= 1'b0; // Second attention prefix; see [RULE11]
    end
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      verbose_ff <= 1'b1; // see [RULE10]
    end else if (line_end && vrb_ok) begin
      verbose_ff <= (line_ff[1] == CH_1); // see [RULE10]
    end
  end

  // ==========================================================================
  // Result selection; acknowledgment is local, no far-end check
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      res_ff <= RES_OK;
      res_go_ff <= 1'b0;
    end else begin
      res_go_ff <= 1'b0;
      if (esc_hit) begin
        res_ff <= RES_OK; // see [RULE8]
        res_go_ff <= 1'b1;
      end else if (line_end) begin
        res_go_ff <= 1'b1;
        if (dial_ok) res_ff <= RES_CONNECT; // see [RULE5] [RULE12]
        else if (hang_ok || vrb_ok || bare_ok) res_ff <= RES_OK; // see [RULE9]
        else res_ff <= RES_ERROR; // see [RULE9]
      end
    end
  end

  // Result text of the current code, index 0 first
  function automatic logic [7:0] res_char(input logic [2:0] r, input logic v,
                                          input logic [3:0] p);
    logic [7:0] s [9];
    int n;
    for (int i = 0; i < 9; i++) s[i] = 8'h00;
    n = 1;
    if (!v) begin
      s[0] = 8'(CH_0 + 8'(r));
    end else if (r == RES_OK) begin
      s[0] = 8'h4f;
      s[1] = 8'h4b;
      n = 2;
    end else if (r == RES_CONNECT) begin
      s[0] = 8'h43;
      s[1] = 8'h4f;
      s[2] = 8'h4e;
      s[3] = 8'h4e;
      s[4] = 8'h45;
      s[5] = 8'h43;
      s[6] = CH_T;
      n = 7;
    end else begin
      s[0] = 8'h45;
      s[1] = 8'h52;
      s[2] = 8'h52;
      s[3] = 8'h4f;
      s[4] = 8'h52;
      n = 5;
    end
    s[n] = CH_CR;
    s[n + 1] = CH_LF;
    res_char = (p < 4'd9) ? s[p] : 8'h00;
  endfunction

  function automatic logic [3:0] res_len(input logic [2:0] r, input logic v);
    if (!v) res_len = 4'd3;
    else if (r == RES_OK) res_len = 4'd4;
    else if (r == RES_CONNECT) res_len = 4'd9;
    else res_len = 4'd7;
  endfunction

  // ==========================================================================
  // Reply stream: echo of command-mode characters, then result text
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      tx_busy_ff <= 1'b0;
      txpos_ff <= 4'd0;
      reply_ff <= '0;
    end else begin
      reply_ff.valid <= 1'b0;
      if (tx_busy_ff) begin
        reply_ff.valid <= 1'b1;
        reply_ff.data <= res_char(res_ff, verbose_ff, txpos_ff);
        txpos_ff <= txpos_ff + 4'd1;
        if (txpos_ff == res_len(res_ff, verbose_ff) - 4'd1) tx_busy_ff <= 1'b0;
      end else if (res_go_ff) begin
        tx_busy_ff <= 1'b1;
        txpos_ff <= 4'd0;
      end else if (chv && !open_ff) begin
        reply_ff.valid <= 1'b1; // see [RULE11]
        reply_ff.data <= host_char_i.data;
      end
    end
  end

  // ==========================================================================
  // Payload gate and network permissions
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      payload_ff <= '0;
      others_block_o <= 1'b0;
      poll_en_o <= 1'b0;
      diag_en_o <= 1'b0;
    end else begin
      payload_ff.valid <= host_char_i.valid && (!dial_mode_enable_i || open_ff); // see [RULE6] [RULE13]
      payload_ff.data <= host_char_i.data;
      others_block_o <= dial_mode_enable_i && open_ff; // see [RULE14]
      poll_en_o <= poll_req_i && (!dial_mode_enable_i || open_ff); // see [RULE15]
      diag_en_o <= diag_req_i; // see [RULE16]
    end
  end

  assign reply_o = reply_ff;
  assign payload_o = payload_ff;
  assign link_o = '{open: open_ff, addr: addr_ff}; // see [RULE13]

  // ==========================================================================
  // Assertions
  a_default_text: assert property (@(posedge clock_i) // see [RULE10]
    $rose(resetn_i) |-> verbose_ff) else $error("verbosity not text after reset");
  a_escape_closes: assert property (@(posedge clock_i) disable iff (!resetn_i) // see [RULE8]
    esc_hit |=> !open_ff ##1 res_ff == RES_OK) else $error("escape did not close");
  a_dial_opens: assert property (@(posedge clock_i) disable iff (!resetn_i) // see [RULE3]
    line_end && dial_ok && !esc_hit |=> open_ff && addr_ff == $past(dial_addr))
    else $error("dial did not open link");
  a_dial_result: assert property (@(posedge clock_i) disable iff (!resetn_i) // see [RULE5]
    line_end && dial_ok |=> ##1 res_ff == RES_CONNECT) else $error("dial result wrong");
  a_error_result: assert property (@(posedge clock_i) disable iff (!resetn_i) // see [RULE9]
    line_end && !(dial_ok || hang_ok || vrb_ok || bare_ok) |=> ##1 res_ff == RES_ERROR)
    else $error("error result wrong");
  a_mode_off_quiet: assert property (@(posedge clock_i) disable iff (!resetn_i) // see [RULE1]
    !dial_mode_enable_i |=> (!open_ff && !reply_o.valid)[*2])
    else $error("parsing while dial mode off");
  a_poll_gated: assert property (@(posedge clock_i) disable iff (!resetn_i) // see [RULE15]
    dial_mode_enable_i && !open_ff |=> !poll_en_o) else $error("poll without link");
  a_diag_free: assert property (@(posedge clock_i) disable iff (!resetn_i) // see [RULE16]
    diag_req_i |=> diag_en_o) else $error("diagnostics blocked");
  a_payload_gate: assert property (@(posedge clock_i) disable iff (!resetn_i) // see [RULE13]
    dial_mode_enable_i && !open_ff |=> !payload_o.valid) else $error("payload leaked");
  // The prefix alone already drops the link, so the answer code is what proves hang-up
  a_hang_closes: assert property (@(posedge clock_i) disable iff (!resetn_i) // see [RULE8]
    line_end && hang_ok |=> !open_ff ##1 res_ff == RES_OK)
    else $error("hang-up did not close with OK");

  c_dial: cover property (@(posedge clock_i) line_end && dial_ok);
  c_escape: cover property (@(posedge clock_i) esc_hit);
  c_numeric: cover property (@(posedge clock_i) line_end && vrb_ok && line_ff[1] == CH_0);
  c_hangup: cover property (@(posedge clock_i) line_end && hang_ok);
  c_second_at: cover property (@(posedge clock_i)
    chv && open_ff && cmd_ff == ST_GOT_A && ch == CH_T);
endmodule // dlp_parser

// ===== bench/dlp_host_model.sv
// Host terminal model on the master's payload port: sends characters.
// Assumes the parser takes one valid strobe per character on clock_i.
`timescale 1ns/1ps
module dlp_host_model
  import dlp_pkg::*;
(
  input wire logic clock_i, // System clock
  output dlp_char_s host_char_o // Character strobe to parser
);
  // ==========================================================================
  // Idle: valid low, data shows inverse of last character
  initial begin
    host_char_o = '{valid: 1'b0, data: 8'h00};
  end
  // One char every two cycles; lines end in CR, digits given in full
  task automatic send(input string s);
    for (int i = 0; i < s.len(); i++) begin
      @(negedge clock_i);
      host_char_o <= '{valid: 1'b1, data: s[i]};
      @(negedge clock_i);
      host_char_o <= '{valid: 1'b0, data: ~s[i]};
    end
    // Leave room for the longest result before the next line
    repeat (14) @(negedge clock_i);
  endtask
endmodule // dlp_host_model

// ===== bench/dlp_parser_tb.sv
// Self-checking bench for the dial link parser.
// Assumes the host model drives characters; reply and payload are recorded.
`timescale 1ns/1ps
module dlp_parser_tb;
  import dlp_pkg::*;
  logic clock_i = 1'b0;
  logic resetn_i = 1'b0;
  logic dial_mode_enable_i = 1'b1;
  logic poll_req_i = 1'b0;
  logic diag_req_i = 1'b0;
  dlp_char_s host_char_i;
  dlp_char_s reply_o;
  dlp_char_s payload_o;
  dlp_link_s link_o;
  logic others_block_o;
  logic poll_en_o;
  logic diag_en_o;
  logic [7:0] rq[$];
  logic [7:0] pq[$];
  int fails = 0;
  int tests_run = 0;
  // ==========================================================================
  // Clock and parts
  always #20 clock_i = ~clock_i;
  dlp_host_model host (.clock_i(clock_i), .host_char_o(host_char_i));
  dlp_parser dut (.clock_i(clock_i), .resetn_i(resetn_i),
    .dial_mode_enable_i(dial_mode_enable_i), .host_char_i(host_char_i),
    .poll_req_i(poll_req_i), .diag_req_i(diag_req_i), .reply_o(reply_o),
    .payload_o(payload_o), .link_o(link_o), .others_block_o(others_block_o),
    .poll_en_o(poll_en_o), .diag_en_o(diag_en_o));
  // Record every strobed character mid-cycle, where the registered pulse has settled
  always @(negedge clock_i) begin
    if (reply_o.valid === 1'b1) rq.push_back(reply_o.data);
    if (payload_o.valid === 1'b1) pq.push_back(payload_o.data);
  end
  // ==========================================================================
  // Checking helpers
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic check_q(ref logic [7:0] q[$], input string e);
    check(q.size(), e.len());
    for (int i = 0; i < e.len() && i < q.size(); i++) check(q[i], e[i]);
    q = {};
  endtask
  task automatic print_verdict;
    if (fails == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    check(link_o, 18'h00000);
    check(others_block_o, 1'b0);
  endtask
  task automatic t_attention;
    host.send("at\r");
    check_q(rq, "at\rOK\r\n");
    host.send("ATX\r");
    check_q(rq, "ATX\rERROR\r\n");
  endtask
  task automatic t_dial_escape;
    host.send("ATV0\r");
    rq = {};
    host.send("AT\r");
    check_q(rq, "AT\r0\r\n");
    // Six digits overrun the argument slots and must be refused
    host.send("ATDT000421\r");
    check_q(rq, "ATDT000421\r4\r\n");
    check(link_o.open, 1'b0);
    poll_req_i <= 1'b1;
    host.send("ATDT00042\r");
    check_q(rq, "ATDT00042\r1\r\n");
    check(link_o, {1'b1, 17'h0002a});
    check(others_block_o, 1'b1);
    check(poll_en_o, 1'b1);
    pq = {};
    host.send("ab+++");
    check_q(pq, "ab+++");
    check_q(rq, "0\r\n");
    check(link_o.open, 1'b0);
    check(poll_en_o, 1'b0);
    host.send("ATV1\r");
    rq = {};
  endtask
  task automatic t_hangup;
    host.send("ATDT65000\r");
    check_q(rq, "ATDT65000\rCONNECT\r\n");
    check(link_o, {1'b1, 17'h0fde8});
    host.send("xyz");
    check(link_o.open, 1'b1);
    check_q(rq, "");
    // Redial while linked: the prefix goes out as payload, the rest is echoed
    host.send("ATDT00042\r");
    check_q(rq, "DT00042\rCONNECT\r\n");
    check(link_o, {1'b1, 17'h0002a});
    host.send("ATH\r");
    check_q(rq, "H\rOK\r\n");
    check(link_o.open, 1'b0);
    pq = {};
  endtask
  task automatic t_reset_mid;
    host.send("ATV0\r");
    host.send("ATDT00042\r");
    check(link_o.open, 1'b1);
    rq = {};
    resetn_i <= 1'b0;
    repeat (2) @(negedge clock_i);
    check(link_o, 18'h00000);
    check(others_block_o, 1'b0);
    resetn_i <= 1'b1;
    @(negedge clock_i);
    host.send("AT\r");
    check_q(rq, "AT\rOK\r\n");
  endtask
  task automatic t_mode_off;
    host.send("ATDT00007\r");
    rq = {};
    diag_req_i <= 1'b1;
    dial_mode_enable_i <= 1'b0;
    repeat (3) @(negedge clock_i);
    check(link_o.open, 1'b0);
    check(others_block_o, 1'b0);
    check(poll_en_o, 1'b1);
    check(diag_en_o, 1'b1);
    pq = {};
    host.send("AT\r");
    check_q(rq, "");
    check_q(pq, "AT\r");
  endtask
  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    repeat (10) @(negedge clock_i);
    t_reset();
    resetn_i <= 1'b1;
    @(negedge clock_i);
    t_attention();
    t_dial_escape();
    t_hangup();
    t_reset_mid();
    t_mode_off();
    print_verdict();
  end
  // Whole sequence takes about 500 cycles; four times that means a hang
  initial begin
    #(40 * 2000);
    fails++;
    print_verdict();
  end
endmodule // dlp_parser_tb
